// [core/iccc_config.sv]
// iccc configuration, watchdog and address remap logic
`include "iccc_defines.svh"
`default_nettype none
module iccc_config #(
  parameter int WD_FAST_CYC = (`ICCC_WD_FAST_US * 1000) / `ICCC_CLK_NS,
  parameter int WD_SLOW_CYC = (`ICCC_WD_SLOW_US / `ICCC_CLK_NS) * 1000,
  parameter logic [6:0] ALIAS0_ADDR = `ICCC_ALIAS0_ADDR
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire iccc_pkg::iccc_reg_req_t req_i,
  output logic [7:0]                  rdata_o,
  output logic                        wr_reject_o,
  input  wire logic                   seq_err_i,
  input  wire logic                   rx_lock_i,
  input  wire logic [6:0]             ser_addr_i,
  input  wire iccc_pkg::iccc_tgt_t     tgt_i,
  output iccc_pkg::iccc_tgt_t          tgt_o,
  output logic                        far_access_en_o,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        scl_oe_o,
  output logic                        bus_free_o,
  output logic [4:0]                  sda_dly_cyc_o
);
  localparam int CNT_W = 26;
  localparam int HALF_CYC = `ICCC_SCL_HALF_NS / `ICCC_CLK_NS;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  far_reg, far_next;
  logic [7:0]  map0_reg, map1_reg;
  logic        lock_d_reg;
  logic [CNT_W-1:0] wd_cnt_reg;
  logic [7:0]  half_cnt_reg;
  logic [4:0]  edge_cnt_reg;
  logic        scl_d_reg, sda_d_reg;
  iccc_pkg::iccc_clr_st_t st_reg;

  wire wr_ok = req_i.wr && !(req_i.remote && ctrl_reg[`ICCC_BIT_LWR_DIS]);
  wire wr_ctrl = wr_ok && req_i.addr == `ICCC_OFS_CTRL2;
  wire wr_far  = wr_ok && req_i.addr == `ICCC_OFS_FAR_ADDR;
  wire wr_map0 = wr_ok && req_i.addr == `ICCC_OFS_MAP0;
  wire wr_map1 = wr_ok && req_i.addr == `ICCC_OFS_MAP1;
  wire clr_err = wr_ctrl && req_i.wdata[`ICCC_BIT_SEQ_CLR];
  wire lock_rise = rx_lock_i && !lock_d_reg;
  wire wd_dis  = ctrl_reg[`ICCC_BIT_WD_DIS];
  wire [CNT_W-1:0] wd_lim = ctrl_reg[`ICCC_BIT_WD_FAST] ?
                     CNT_W'(WD_FAST_CYC) : CNT_W'(WD_SLOW_CYC);
  wire activity = (scl_i != scl_d_reg) || (sda_i != sda_d_reg);
  wire expired  = !wd_dis && wd_cnt_reg >= wd_lim;
  wire [1:0] dly_code = ctrl_reg[`ICCC_BIT_DLY_HI:`ICCC_BIT_DLY_LO];
  wire [9:0] dly_ns = 10'(`ICCC_DLY_BASE_NS) +
                      10'(`ICCC_DLY_STEP_NS) * {8'h00, dly_code};
  wire [4:0] dly_cyc = 5'((dly_ns + 10'(`ICCC_CLK_NS - 1)) / 10'(`ICCC_CLK_NS));
  wire [7:0] rd_mux = (req_i.addr == `ICCC_OFS_CTRL2)    ? ctrl_reg :
                      (req_i.addr == `ICCC_OFS_FAR_ADDR) ? far_reg  :
                      (req_i.addr == `ICCC_OFS_MAP0)     ? map0_reg :
                      (req_i.addr == `ICCC_OFS_MAP1)     ? map1_reg : 8'h00;
  // alias slot register sits outside this block
  wire alias0 = tgt_i.valid && tgt_i.addr == ALIAS0_ADDR;

  // status bit: set wins over clear, sticky otherwise
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next[4:0] = req_i.wdata[4:0];
      ctrl_next[`ICCC_BIT_SEQ_CLR] = 1'b0;
    end
    if (clr_err) begin
      ctrl_next[`ICCC_BIT_SEQ_ERR] = 1'b0;
    end
    if (seq_err_i) begin
      ctrl_next[`ICCC_BIT_SEQ_ERR] = 1'b1;
    end
    ctrl_next[5] = 1'b0;
  end

  always_comb begin
    far_next = far_reg;
    if (lock_rise && !far_reg[`ICCC_BIT_HOLD]) begin
      far_next[7:1] = ser_addr_i;
    end
    if (wr_far) begin
      far_next = req_i.wdata;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg   <= `ICCC_RST_REG;
      far_reg    <= `ICCC_RST_REG;
      lock_d_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      far_reg    <= far_next;
      lock_d_reg <= rx_lock_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      map0_reg <= `ICCC_RST_REG;
      map1_reg <= `ICCC_RST_REG;
    end else begin
      if (wr_map0) map0_reg <= req_i.wdata;
      if (wr_map1) map1_reg <= req_i.wdata;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o         <= 8'h00;
      wr_reject_o     <= 1'b0;
      tgt_o           <= '0;
      far_access_en_o <= 1'b0;
      sda_dly_cyc_o   <= 5'h00;
    end else begin
      rdata_o         <= req_i.rd ? rd_mux : 8'h00;
      wr_reject_o     <= req_i.wr && !wr_ok;
      tgt_o.valid     <= tgt_i.valid;
      tgt_o.addr      <= alias0 ? map0_reg[7:1] : tgt_i.addr;
      far_access_en_o <= far_reg[7:1] != 7'h00;
      sda_dly_cyc_o   <= dly_cyc;
    end
  end

  // bus watchdog: idle counter, then free flag or nine-pulse recovery
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      wd_cnt_reg   <= '0;
      bus_free_o   <= 1'b0;
      scl_oe_o     <= 1'b0;
      half_cnt_reg <= 8'h00;
      edge_cnt_reg <= 5'h00;
      st_reg       <= iccc_pkg::ICCC_WD_IDLE;
    end else begin
      scl_d_reg <= scl_i;
      sda_d_reg <= sda_i;
      case (st_reg)
        iccc_pkg::ICCC_WD_IDLE: begin
          scl_oe_o <= 1'b0;
          if (wd_dis || activity) begin
            wd_cnt_reg <= '0;
            bus_free_o <= 1'b0;
          end else if (expired) begin
            wd_cnt_reg <= '0;
            if (sda_i) begin
              bus_free_o <= 1'b1;
            end else begin
              bus_free_o   <= 1'b0;
              st_reg       <= iccc_pkg::ICCC_WD_LOW;
              edge_cnt_reg <= 5'h00;
              half_cnt_reg <= 8'h00;
            end
          end else if (!bus_free_o) begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
          end
        end
        iccc_pkg::ICCC_WD_LOW: begin
          scl_oe_o <= 1'b1;
          if (half_cnt_reg == 8'(HALF_CYC - 1)) begin
            half_cnt_reg <= 8'h00;
            st_reg       <= iccc_pkg::ICCC_WD_HIGH;
          end else begin
            half_cnt_reg <= half_cnt_reg + 8'h01;
          end
        end
        iccc_pkg::ICCC_WD_HIGH: begin
          scl_oe_o <= 1'b0;
          if (half_cnt_reg == 8'(HALF_CYC - 1)) begin
            half_cnt_reg <= 8'h00;
            if (edge_cnt_reg == 5'(`ICCC_CLR_PULSES - 1)) begin
              st_reg <= iccc_pkg::ICCC_WD_IDLE;
            end else begin
              edge_cnt_reg <= edge_cnt_reg + 5'h01;
              st_reg       <= iccc_pkg::ICCC_WD_LOW;
            end
          end else begin
            half_cnt_reg <= half_cnt_reg + 8'h01;
          end
        end
        default: st_reg <= iccc_pkg::ICCC_WD_IDLE;
      endcase
    end
  end

  logic [4:0] pulse_cnt_reg;
  logic       scl_oe_d_reg;
  // counts recovery pulses so the assertion can bound them
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt_reg <= 5'h00;
      scl_oe_d_reg  <= 1'b0;
    end else begin
      scl_oe_d_reg <= scl_oe_o;
      if (st_reg == iccc_pkg::ICCC_WD_IDLE) begin
        pulse_cnt_reg <= 5'h00;
      end else if (scl_oe_o && !scl_oe_d_reg) begin
        pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
      end
    end
  end

  // named steps of the status flag and of the recovery
  sequence s_err_pulse;
    seq_err_i;
  endsequence
  sequence s_enter_recovery;
    st_reg == iccc_pkg::ICCC_WD_IDLE && expired && !activity && !sda_i;
  endsequence
  sequence s_pulse_start;
    scl_oe_o && !scl_oe_d_reg;
  endsequence
  sequence s_low_hold;
    scl_oe_o [*8];
  endsequence

  // status flag
  chk_err_sets: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    s_err_pulse |=> ctrl_reg[7])
    else $error("sequence error not flagged");
  chk_err_ro: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wr_ctrl && !seq_err_i && !ctrl_reg[7] |=> !ctrl_reg[7])
    else $error("status bit written by software");
  chk_err_sticky: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ctrl_reg[7] && !clr_err |=> ctrl_reg[7])
    else $error("sequence error dropped without clear");
  chk_err_clear: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    clr_err && !seq_err_i |=> !ctrl_reg[7])
    else $error("sequence error not cleared");
  chk_clr_self: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wr_ctrl |=> !ctrl_reg[`ICCC_BIT_SEQ_CLR])
    else $error("clear bit did not return to zero");

  // delay and write blocking
  chk_dly_value: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> sda_dly_cyc_o == 5'h07 + {3'h0, $past(dly_code)})
    else $error("output delay wrong");
  chk_remote_block: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    req_i.wr && req_i.remote && ctrl_reg[2] && req_i.addr == 8'h07
    |=> $stable(far_reg) || $past(lock_rise))
    else $error("remote write not blocked");
  chk_reject_pulse: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    req_i.wr && req_i.remote && ctrl_reg[2] |=> wr_reject_o)
    else $error("remote write not reported refused");
  chk_local_pass: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    req_i.wr && !req_i.remote |=> !wr_reject_o)
    else $error("local write refused");

  // bus watchdog
  chk_wd_off: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wd_dis && st_reg == iccc_pkg::ICCC_WD_IDLE |=> !scl_oe_o)
    else $error("watchdog acted while disabled");
  chk_dis_no_free: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wd_dis |=> !bus_free_o)
    else $error("bus free flagged while disabled");
  chk_free_high: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    st_reg == iccc_pkg::ICCC_WD_IDLE && expired && !activity && sda_i
    |=> bus_free_o)
    else $error("bus not declared free");
  chk_free_holds: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    bus_free_o && !wd_dis && !activity |=> bus_free_o)
    else $error("bus free dropped while idle");
  chk_recover_start: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    s_enter_recovery |=> st_reg == iccc_pkg::ICCC_WD_LOW)
    else $error("recovery not started");
  chk_pulse_low: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    s_pulse_start |-> s_low_hold)
    else $error("recovery pulse too short");
  chk_nine_pulses: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    pulse_cnt_reg <= 5'(`ICCC_CLR_PULSES))
    else $error("too many recovery pulses");
  chk_fast_limit: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    wd_cnt_reg <= wd_lim || $past(!ctrl_reg[1]))
    else $error("watchdog limit exceeded");

  // far address and remap
  chk_autoload: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    lock_rise && !far_reg[0] && !wr_far
    |=> far_reg[7:1] == $past(ser_addr_i))
    else $error("far address not loaded");
  chk_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    far_reg[0] && !wr_far |=> $stable(far_reg))
    else $error("held far address changed");
  chk_remap: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    alias0 |=> tgt_o.addr == $past(map0_reg[7:1]))
    else $error("alias not remapped");
  chk_remap_pass: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    tgt_i.valid && !alias0 |=> tgt_o.addr == $past(tgt_i.addr))
    else $error("plain address altered");
  chk_far_zero: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    far_reg[7:1] == 7'h00 |=> !far_access_en_o)
    else $error("zero far address enabled access");
  chk_far_nonzero: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    far_reg[7:1] != 7'h00 |=> far_access_en_o)
    else $error("far address access not enabled");
endmodule // iccc_config
`default_nettype wire

// [shared/iccc_defines.svh]
// iccc constants: offsets, fields, resets, timing
// Functional notes
// - sequence error on forward channel sets read-only status bit 7.
// - writing one to bit 6 clears the sequence error status bit.
// - bits 4-3 set data output delay, 250ns plus 50ns per code step.
// - bit 1 picks watchdog expiry: about 50us when one, about 1s when zero.
// - bit 0 set disables the bus watchdog in idle; a recovery already under way still runs to its end.
// - data high and idle until expiry means bus is treated as free.
// - data low and idle until expiry triggers nine clock pulses on clock line.
// - after receive lock, auto-load far address from serializer unless frozen.
// - hold bit 0 set suppresses auto-load; written value stays.
// - alias slot 0 transactions get address replaced by target map 0 value.
`ifndef ICCC_DEFINES_SVH
`define ICCC_DEFINES_SVH
`define ICCC_OFS_CTRL2     8'h06
`define ICCC_OFS_FAR_ADDR  8'h07
`define ICCC_OFS_MAP0      8'h08
`define ICCC_OFS_MAP1      8'h09
`define ICCC_RST_REG       8'h00
`define ICCC_BIT_SEQ_ERR   7
`define ICCC_BIT_SEQ_CLR   6
`define ICCC_BIT_DLY_HI    4
`define ICCC_BIT_DLY_LO    3
`define ICCC_BIT_LWR_DIS   2
`define ICCC_BIT_WD_FAST   1
`define ICCC_BIT_WD_DIS    0
`define ICCC_BIT_HOLD      0
`define ICCC_CLK_NS        40
`define ICCC_DLY_BASE_NS   250
`define ICCC_DLY_STEP_NS   50
`define ICCC_WD_FAST_US    50
`define ICCC_WD_SLOW_US    1000000
`define ICCC_SCL_HALF_NS   2000
`define ICCC_CLR_PULSES    9
// alias slot 0 address, default value arbitrary
`define ICCC_ALIAS0_ADDR   7'h20
`endif

// [shared/iccc_pkg.sv]
// iccc types: register bus and alias translation carriers
`default_nettype none
package iccc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iccc_reg_req_t;
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } iccc_tgt_t;
  typedef enum {ICCC_WD_IDLE, ICCC_WD_LOW, ICCC_WD_HIGH} iccc_clr_st_t;
endpackage
`default_nettype wire

// [tb/iccc_far_model.sv]
// far serializer model: receive lock, reported address, sequence error
`default_nettype none
module iccc_far_model (
  input  wire logic       mclk_i,
  input  wire logic       link_up_i,
  input  wire logic [6:0] id_i,
  input  wire logic       err_i,
  output logic            rx_lock_o,
  output logic [6:0]      ser_addr_o,
  output logic            seq_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lock_sh;
  initial lock_sh = 2'h0;
  initial seq_err_o = 1'b0;
  always @(posedge mclk_i) begin
    lock_sh <= link_up_i ? {lock_sh[0], 1'b1} : 2'h0;
    seq_err_o <= err_i;
  end
  assign rx_lock_o = lock_sh[1];
  // address valid only while locked, inverted garbage otherwise
  assign ser_addr_o = rx_lock_o ? id_i : ~id_i;
endmodule // iccc_far_model
`default_nettype wire

// [tb/tb.sv]
// bench for the control-channel configuration block
`include "iccc_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_i, sda_drv, link_up, err_in, rej;
  logic [6:0] id, id2, p, q;
  logic [7:0] rd, rdata_o;
  logic wr_reject_o, rx_lock, seq_err, far_access_en_o, scl_oe_o;
  logic bus_free_o;
  logic [6:0] ser_addr;
  logic [4:0] sda_dly_cyc_o;
  iccc_pkg::iccc_reg_req_t req;
  iccc_pkg::iccc_tgt_t tgt_in, tgt_o;
  int mismatches, checked, n;
  iccc_config #(.WD_FAST_CYC(50), .WD_SLOW_CYC(200)) iccc_config_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
    .wr_reject_o(wr_reject_o), .seq_err_i(seq_err), .rx_lock_i(rx_lock),
    .ser_addr_i(ser_addr), .tgt_i(tgt_in), .tgt_o(tgt_o),
    .far_access_en_o(far_access_en_o), .scl_i(~scl_oe_o), .sda_i(sda_drv),
    .scl_oe_o(scl_oe_o), .bus_free_o(bus_free_o),
    .sda_dly_cyc_o(sda_dly_cyc_o));
  iccc_far_model iccc_far_model_i (.mclk_i(mclk_i), .link_up_i(link_up),
    .id_i(id), .err_i(err_in), .rx_lock_o(rx_lock), .ser_addr_o(ser_addr),
    .seq_err_o(seq_err));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [4:0] dly_exp(int c);
    return 5'((`ICCC_DLY_BASE_NS + `ICCC_DLY_STEP_NS * c
               + `ICCC_CLK_NS - 1) / `ICCC_CLK_NS);
  endfunction
  task automatic cyc(int k);
    repeat (k) @(negedge mclk_i);
  endtask
  // one request cycle, answer sampled one cycle later
  task automatic bus(logic w, logic rem, logic [7:0] a, logic [7:0] d);
    req = '{wr: w, rd: ~w, remote: rem, addr: a, wdata: d};
    cyc(1);
    rd = rdata_o;
    rej = wr_reject_o;
    req = '0;
    cyc(1);
  endtask
  // bounded wait on scl_oe_o (sel 0) or bus_free_o (sel 1)
  task automatic wait_hi(int sel, int lim);
    int i;
    for (i = 0; i < lim && (sel ? bus_free_o : scl_oe_o) !== 1'b1; i++)
      cyc(1);
    if (i == lim) begin
      chk("wait_timeout", 8'h01, 8'h00);
      end_sim();
    end
  endtask
  initial begin
    mismatches = 0;
    checked = 0;
    req = '0;
    tgt_in = '0;
    sda_drv = 1'b1;
    link_up = 1'b0;
    err_in = 1'b0;
    id = 7'h00;
    void'($urandom(68435));
    rst_i = 1'b1;
    cyc(3);
    rst_i = 1'b0;
    cyc(1);
    for (int a = 6; a <= 10; a++) begin
      bus(0, 0, 8'(a), 8'h00);
      chk("reset_value", rd, 8'h00);
    end
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      bus(1, 0, `ICCC_OFS_CTRL2, 8'(c << 3) | 8'hE6);
      chk("sda_delay", 8'(sda_dly_cyc_o), 8'(dly_exp(c)));
      bus(0, 0, `ICCC_OFS_CTRL2, 8'h00);
      chk("ctrl_readback", rd, 8'(c << 3) | 8'h06);
    end
    bus(1, 0, `ICCC_OFS_CTRL2, 8'h00);
    $display("test delay done");
    err_in = 1'b1;
    cyc(1);
    err_in = 1'b0;
    cyc(3);
    bus(0, 0, `ICCC_OFS_CTRL2, 8'h00);
    chk("seq_err_set", rd, 8'h80);
    cyc(20);
    bus(0, 0, `ICCC_OFS_CTRL2, 8'h00);
    chk("seq_err_sticky", rd, 8'h80);
    bus(1, 0, `ICCC_OFS_CTRL2, 8'h40);
    bus(0, 0, `ICCC_OFS_CTRL2, 8'h00);
    chk("seq_err_clear", rd, 8'h00);
    $display("test seq_err done");
    p = 7'($urandom_range(1, 127));
    bus(1, 0, `ICCC_OFS_CTRL2, 8'h04);
    bus(1, 1, `ICCC_OFS_MAP0, {p, 1'b0});
    chk("remote_refused", 8'(rej), 8'h01);
    bus(0, 0, `ICCC_OFS_MAP0, 8'h00);
    chk("map0_kept", rd, 8'h00);
    bus(1, 0, `ICCC_OFS_CTRL2, 8'h00);
    bus(1, 1, `ICCC_OFS_MAP0, {p, 1'b0});
    chk("remote_taken", 8'(rej), 8'h00);
    bus(0, 0, `ICCC_OFS_MAP0, 8'h00);
    chk("map0_written", rd, {p, 1'b0});
    q = `ICCC_ALIAS0_ADDR ^ 7'h01;
    tgt_in = '{valid: 1'b1, addr: `ICCC_ALIAS0_ADDR};
    cyc(1);
    tgt_in = '{valid: 1'b1, addr: q};
    chk("alias_remap", 8'(tgt_o), {1'b1, p});
    cyc(1);
    chk("alias_pass", 8'(tgt_o), {1'b1, q});
    tgt_in = '0;
    $display("test remote_map done");
    id = 7'($urandom_range(1, 127));
    id2 = id ^ 7'h55;
    link_up = 1'b1;
    cyc(5);
    bus(0, 0, `ICCC_OFS_FAR_ADDR, 8'h00);
    chk("auto_load", rd, {id, 1'b0});
    chk("far_enable", 8'(far_access_en_o), 8'h01);
    link_up = 1'b0;
    bus(1, 0, `ICCC_OFS_FAR_ADDR, {id2, 1'b1});
    id = id2 ^ 7'h0F;
    link_up = 1'b1;
    cyc(5);
    bus(0, 0, `ICCC_OFS_FAR_ADDR, 8'h00);
    chk("held_addr", rd, {id2, 1'b1});
    bus(1, 0, `ICCC_OFS_FAR_ADDR, 8'h01);
    cyc(2);
    chk("far_disable", 8'(far_access_en_o), 8'h00);
    $display("test far_addr done");
    bus(1, 0, `ICCC_OFS_CTRL2, 8'h01);
    sda_drv = 1'b0;
    n = 0;
    repeat (400) begin
      cyc(1);
      n += int'(scl_oe_o === 1'b1);
    end
    chk("wd_disabled", 8'(n), 8'h00);
    bus(1, 0, `ICCC_OFS_CTRL2, 8'h00);
    wait_hi(0, 400);
    n = 1;
    repeat (1000) begin
      rej = scl_oe_o;
      cyc(1);
      n += int'(scl_oe_o === 1'b1 && rej === 1'b0);
    end
    chk("clear_pulses", 8'(n), 8'(`ICCC_CLR_PULSES));
    sda_drv = 1'b1;
    wait_hi(1, 400);
    chk("bus_free", 8'(bus_free_o), 8'h01);
    bus(1, 0, `ICCC_OFS_CTRL2, 8'h02);
    sda_drv = 1'b0;
    cyc(40);
    chk("fast_not_early", 8'(scl_oe_o), 8'h00);
    wait_hi(0, 40);
    sda_drv = 1'b1;
    chk("fast_expiry", 8'(scl_oe_o), 8'h01);
    $display("test watchdog done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
